// [hw/ccr_top.sv]
`timescale 1ns/100ps
`include "ccr_regs.svh"
module ccr_top #(
   parameter int WAKE_DLY_CYC = (`CCR_WAKE_T_NS + `CCR_CLK_NS - 1) / `CCR_CLK_NS
) (
   // clock and power-on reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // oscillator pins and straps
   input wire logic [3:0] osc_pin,
   input wire ccr_pkg::ccr_src_t cfg_src,
   input wire logic rtc_on_xtal,
   // other reset sources and wake-up
   input wire logic [3:0] rst_req,
   input wire logic wake_req,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // derived clocks
   output logic cpu_tick,
   output logic periph_tick,
   output logic periph_clk,
   output logic machine_cycle,
   // clock output pin
   output logic clkout,
   output logic clkout_oe,
   // control levels
   output logic [5:0] trim,
   output logic low_power,
   output logic [7:0] wdt_ctrl,
   output logic irq
);
   import ccr_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int NSYNC = 7;
   wire [NSYNC-1:0] raw_w = {rtc_on_xtal, cfg_src, osc_pin};
   wire [NSYNC-1:0] sync_w;

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         logic m_r;
         logic q_r;
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               m_r <= 1'b0;
               q_r <= 1'b0;
            end else begin
               m_r <= raw_w[gi];
               q_r <= m_r;
            end
         end
         assign sync_w[gi] = q_r;
      end
   endgenerate

   wire [3:0] osc_s_w = sync_w[3:0];
   wire [1:0] src_s_w = sync_w[5:4];
   wire rtc_s_w = sync_w[6];

   // ----------------------------------------
   // source strap and oscillator edges
   // ----------------------------------------
   logic [1:0] cap_cnt_r;
   ccr_src_t src_r;
   logic osc_prev_r;
   wire cap_done_w = (cap_cnt_r == 2'h3);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cap_cnt_r <= 2'h0;
         src_r <= CCR_SRC_XTAL;
      end else if (!cap_done_w) begin
         cap_cnt_r <= cap_cnt_r + 2'h1;
         src_r <= ccr_src_t'(src_s_w);
      end
   end

   wire osc_sel_w = osc_s_w[src_r];
   wire osc_tick_w = osc_sel_w & ~osc_prev_r & cap_done_w;
   wire soft_rst_w = |rst_req;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_prev_r <= 1'b0;
      end else begin
         osc_prev_r <= osc_sel_w;
      end
   end

   chk_src_fixed: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (cap_done_w && $past(cap_done_w)) |-> $stable(src_r))
      else $error("clock source moved after capture");

   // ----------------------------------------
   // wake-up timer
   // ----------------------------------------
   localparam logic [12:0] DLY_LAST = 13'(WAKE_DLY_CYC - 1);
   ccr_wake_t st_r;
   ccr_wake_t st_nxt;
   logic [12:0] wcnt_r;
   logic [12:0] wcnt_nxt;
   wire [9:0] osc_tgt_w = (src_r == CCR_SRC_XTAL) ? `CCR_WAKE_XTAL : `CCR_WAKE_OTHER;
   wire [12:0] osc_last_w = {3'h0, osc_tgt_w} - 13'h0001;

   always_comb begin
      st_nxt = st_r;
      wcnt_nxt = wcnt_r;
      case (st_r)
         CCR_WK_OSC: begin
            if (osc_tick_w) begin
               if (wcnt_r == osc_last_w) begin
                  st_nxt = CCR_WK_US;
                  wcnt_nxt = 13'h0000;
               end else begin
                  wcnt_nxt = wcnt_r + 13'h0001;
               end
            end
         end
         CCR_WK_US: begin
            if (wcnt_r == DLY_LAST) begin
               st_nxt = CCR_WK_RUN;
               wcnt_nxt = 13'h0000;
            end else begin
               wcnt_nxt = wcnt_r + 13'h0001;
            end
         end
         CCR_WK_RUN: begin
            if (wake_req) begin
               st_nxt = CCR_WK_OSC;
            end
         end
         default: begin
            st_nxt = CCR_WK_OSC;
            wcnt_nxt = 13'h0000;
         end
      endcase
      if (soft_rst_w) begin
         st_nxt = CCR_WK_OSC;
         wcnt_nxt = 13'h0000;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= CCR_WK_OSC;
         wcnt_r <= 13'h0000;
      end else begin
         st_r <= st_nxt;
         wcnt_r <= wcnt_nxt;
      end
   end

   wire run_w = (st_r == CCR_WK_RUN);
   wire wake_done_w = (st_r == CCR_WK_US) && (st_nxt == CCR_WK_RUN);

   sequence s_enter_us;
      (st_r == CCR_WK_OSC) ##1 (st_r == CCR_WK_US);
   endsequence

   sequence s_enter_run;
      (st_r == CCR_WK_US) ##1 (st_r == CCR_WK_RUN);
   endsequence

   chk_xtal_wake: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      s_enter_us ##0 (src_r == CCR_SRC_XTAL) |-> $past(wcnt_r) == 13'h03DF)
      else $error("crystal wake count is not 992");

   chk_other_wake: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      s_enter_us ##0 (src_r != CCR_SRC_XTAL) |-> $past(wcnt_r) == 13'h00DF)
      else $error("non-crystal wake count is not 224");

   chk_us_delay: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      s_enter_run |-> $past(wcnt_r) == DLY_LAST)
      else $error("fixed wake delay has wrong length");

   // ----------------------------------------
   // register bus
   // ----------------------------------------
   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      return a == ofs;
   endfunction : hit

   logic ack_r;
   logic [7:0] rdata_r;
   logic [7:0] div_r;
   logic [5:0] trim_r;
   logic clock_output_enable_r;
   logic lp_r;
   logic [7:0] cause_r;
   logic [7:0] wdc_r;
   logic [1:0] ist_r;
   logic [1:0] imsk_r;

   wire req_w = avs_read | avs_write;
   // one wait state on every access, read data latched meanwhile
   assign avs_waitrequest = req_w & ~ack_r;
   // a reset request in the same cycle beats a bus write
   wire wr_w = avs_write & ack_r & avs_byteenable[0] & ~soft_rst_w;
   wire [7:0] wd_w = avs_writedata[7:0];

   wire sel_div_w = hit(avs_address, `CCR_OFS_DIV);
   wire sel_trim_w = hit(avs_address, `CCR_OFS_TRIM);
   wire sel_aux_w = hit(avs_address, `CCR_OFS_AUX);
   wire sel_cause_w = hit(avs_address, `CCR_OFS_CAUSE);
   wire sel_wdc_w = hit(avs_address, `CCR_OFS_WDC);
   wire sel_ist_w = hit(avs_address, `CCR_OFS_IST);
   wire sel_imsk_w = hit(avs_address, `CCR_OFS_IMSK);
   wire sel_stat_w = hit(avs_address, `CCR_OFS_STAT);

   wire [7:0] rd_mux_w =
      sel_div_w ? div_r :
      sel_trim_w ? {1'b0, clock_output_enable_r, trim_r} :
      sel_aux_w ? {lp_r, 7'h00} :
      sel_cause_w ? cause_r :
      sel_wdc_w ? wdc_r :
      sel_ist_w ? {6'h00, ist_r} :
      sel_imsk_w ? {6'h00, imsk_r} :
      sel_stat_w ? {5'h00, src_r, run_w} : 8'h00;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         ack_r <= req_w & ~ack_r;
         if (req_w && !ack_r) begin
            rdata_r <= rd_mux_w;
         end
      end
   end

   assign avs_readdata = {24'h00_0000, rdata_r};

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   wire [7:0] div_nxt = soft_rst_w ? `CCR_DIV_RST : (wr_w & sel_div_w) ? wd_w : div_r;
   wire [5:0] trim_nxt = (wr_w & sel_trim_w) ? wd_w[5:0] : trim_r;
   wire clock_output_enable_nxt = (wr_w & sel_trim_w) ? wd_w[`CCR_TRIM_CLOCK_OUTPUT_ENABLE] : clock_output_enable_r;
   wire lp_nxt = soft_rst_w ? 1'b0 : (wr_w & sel_aux_w) ? wd_w[`CCR_AUX_LP] : lp_r;
   // causes sticky, write one clears, set wins
   wire [7:0] cause_set_w = {2'h0, rst_req[0], 1'b0, rst_req[3:1], 1'b0};
   wire [7:0] cause_clr_w = (wr_w & sel_cause_w) ? wd_w : 8'h00;
   wire [7:0] cause_nxt = (cause_r & ~cause_clr_w) | cause_set_w;
   wire wdc_tof_w = rst_req[1] | wdc_r[`CCR_WDC_TOF];
   wire [7:0] wdc_soft_w = `CCR_WDC_RST | {6'h00, wdc_tof_w, 1'b0};
   wire [7:0] wdc_nxt = soft_rst_w ? wdc_soft_w :
                        (wr_w & sel_wdc_w) ? (wd_w & `CCR_WDC_MASK) : wdc_r;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= `CCR_DIV_RST;
         trim_r <= `CCR_TRIM_FACT;
         clock_output_enable_r <= 1'b0;
         lp_r <= 1'b0;
         cause_r <= `CCR_CAUSE_POR;
         wdc_r <= `CCR_WDC_RST;
      end else begin
         div_r <= div_nxt;
         trim_r <= trim_nxt;
         clock_output_enable_r <= clock_output_enable_nxt;
         lp_r <= lp_nxt;
         cause_r <= cause_nxt;
         wdc_r <= wdc_nxt;
      end
   end

   logic por_seen_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         por_seen_r <= 1'b0;
      end else begin
         por_seen_r <= 1'b1;
      end
   end

   chk_cause_por: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !por_seen_r |-> cause_r == 8'h30)
      else $error("power-on cause pattern wrong");

   chk_trim_keep: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      soft_rst_w |=> $stable(trim_r) && $stable(clock_output_enable_r))
      else $error("soft reset disturbed trim");

   chk_trim_write: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (wr_w && sel_trim_w) |=> trim_r == $past(wd_w[5:0]))
      else $error("trim write lost");

   chk_lp_reset: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      soft_rst_w |=> !lp_r)
      else $error("low power bit survived reset");

   chk_wdc_reset: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      soft_rst_w |=> wdc_r[7:2] == 6'h39 && wdc_r[0] &&
         wdc_r[1] == ($past(rst_req[1]) || $past(wdc_r[1])))
      else $error("watchdog control reset value wrong");

   // ----------------------------------------
   // divider and derived clocks
   // ----------------------------------------
   ccr_div_if dv_if();
   assign dv_if.osc_tick = osc_tick_w;
   assign dv_if.run = run_w;
   assign dv_if.div_val = div_r;

   ccr_divider u_div (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .dv(dv_if)
   );

   logic ph_r;
   logic cpu_tick_r;
   logic periph_tick_r;
   logic clkout_oe_r;
   logic irq_r;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_r <= 1'b0;
         cpu_tick_r <= 1'b0;
         periph_tick_r <= 1'b0;
      end else begin
         ph_r <= ph_r ^ dv_if.cpu_tick;
         cpu_tick_r <= dv_if.cpu_tick;
         periph_tick_r <= dv_if.cpu_tick & ph_r;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         clkout_oe_r <= 1'b0;
      end else begin
         clkout_oe_r <= clock_output_enable_r & (src_r != CCR_SRC_XTAL) & ~rtc_s_w;
      end
   end

   chk_pclk_half: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      $changed(ph_r) == cpu_tick_r)
      else $error("peripheral phase not locked to cpu clock");

   chk_mcycle_pair: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      periph_tick_r |-> cpu_tick_r && !ph_r)
      else $error("machine cycle not on second cpu clock");

   chk_wake_gate: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !run_w |=> !cpu_tick_r)
      else $error("cpu clock ran during wake-up");

   chk_clkout_oe: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      clkout_oe |-> $past(clock_output_enable_r) && !$past(rtc_s_w) && $past(src_r) != CCR_SRC_XTAL)
      else $error("clock pin driven while not allowed");

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   wire div_chg_w = dv_if.load & run_w & (dv_if.div_cur != div_r);
   wire [1:0] ev_w = {div_chg_w, wake_done_w};
   wire [1:0] ist_clr_w = (wr_w & sel_ist_w) ? wd_w[1:0] : 2'h0;
   wire [1:0] ist_nxt = soft_rst_w ? 2'h0 : (ist_r & ~ist_clr_w) | ev_w;
   wire [1:0] imsk_nxt = soft_rst_w ? 2'h0 : (wr_w & sel_imsk_w) ? wd_w[1:0] : imsk_r;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ist_r <= 2'h0;
         imsk_r <= 2'h0;
         irq_r <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         imsk_r <= imsk_nxt;
         irq_r <= |(ist_r & imsk_r);
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign cpu_tick = cpu_tick_r;
   assign periph_tick = periph_tick_r;
   assign periph_clk = ph_r;
   assign machine_cycle = periph_tick_r;
   assign clkout = ph_r;
   assign clkout_oe = clkout_oe_r;
   assign trim = trim_r;
   assign low_power = lp_r;
   assign wdt_ctrl = wdc_r;
   assign irq = irq_r;
endmodule : ccr_top

// [hw/ccr_regs.svh]
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CCR_OFS_DIV   5'h00
`define CCR_OFS_TRIM  5'h04
`define CCR_OFS_AUX   5'h08
`define CCR_OFS_CAUSE 5'h0C
`define CCR_OFS_WDC   5'h10
`define CCR_OFS_IST   5'h14
`define CCR_OFS_IMSK  5'h18
`define CCR_OFS_STAT  5'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCR_TRIM_CLOCK_OUTPUT_ENABLE 6
`define CCR_AUX_LP     7
`define CCR_CAUSE_BOF  5
`define CCR_CAUSE_POF  4
`define CCR_WDC_TOF    1

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define CCR_DIV_RST    8'h00
`define CCR_TRIM_FACT  6'h20
`define CCR_CAUSE_POR  8'h30
`define CCR_WDC_RST    8'hE5
`define CCR_WDC_MASK   8'hE7

// ----------------------------------------
// timing
// ----------------------------------------
`define CCR_WAKE_XTAL  10'h3E0
`define CCR_WAKE_OTHER 10'h0E0
`define CCR_WAKE_T_NS  60000
`define CCR_CLK_NS     10

`endif

// [hw/ccr_pkg.sv]
package ccr_pkg;
   typedef enum logic [1:0] {
      CCR_SRC_XTAL,
      CCR_SRC_RC,
      CCR_SRC_WDOG,
      CCR_SRC_EXT
   } ccr_src_t;

   typedef enum logic [1:0] {
      CCR_WK_OSC,
      CCR_WK_US,
      CCR_WK_RUN
   } ccr_wake_t;
endpackage : ccr_pkg

// [hw/ccr_div_if.sv]
`timescale 1ns/100ps
interface ccr_div_if;
   logic osc_tick;
   logic run;
   logic [7:0] div_val;
   logic cpu_tick;
   logic load;
   logic [7:0] div_cur;
   modport ctl (output osc_tick, output run, output div_val,
                input cpu_tick, input load, input div_cur);
   modport div (input osc_tick, input run, input div_val,
                output cpu_tick, output load, output div_cur);
endinterface : ccr_div_if

// [hw/ccr_divider.sv]
`timescale 1ns/100ps
`include "ccr_regs.svh"
module ccr_divider (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // divider link
   ccr_div_if.div dv
);
   logic [8:0] cnt_r;
   logic [7:0] cur_r;
   logic [8:0] gap_r;

   wire [8:0] last_w = (cur_r == 8'h00) ? 9'h000 : {cur_r, 1'b0} - 9'h001;
   wire [8:0] period_w = (cur_r == 8'h00) ? 9'h001 : {cur_r, 1'b0};
   // zero passes through, n counts 2n
   wire wrap_w = dv.osc_tick & (cnt_r == last_w);

   // new value taken at a period boundary or while stopped, so no runt cycle
   assign dv.load = wrap_w | ~dv.run;
   assign dv.cpu_tick = wrap_w & dv.run;
   assign dv.div_cur = cur_r;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 9'h000;
         cur_r <= `CCR_DIV_RST;
      end else begin
         if (!dv.run || wrap_w) begin
            cnt_r <= 9'h000;
         end else if (dv.osc_tick) begin
            cnt_r <= cnt_r + 9'h001;
         end
         if (dv.load) begin
            cur_r <= dv.div_val;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gap_r <= 9'h000;
      end else if (!dv.run || dv.cpu_tick) begin
         gap_r <= 9'h000;
      end else if (dv.osc_tick) begin
         gap_r <= gap_r + 9'h001;
      end
   end

   chk_div_period: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      dv.cpu_tick |-> (gap_r + 9'h001 == period_w))
      else $error("cpu period differs from divider setting");

   chk_div_hold: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (dv.run && !wrap_w) |=> $stable(cur_r))
      else $error("divider value changed inside a period");
endmodule : ccr_divider

// [bench/ccr_osc_model.sv]
`timescale 1ns/100ps
// ------------------------------
// oscillator sources
// ------------------------------
module ccr_osc_model #(
   parameter int HALF = 2
) (
   // clock
   input wire logic sys_clk,
   // oscillator pins
   output logic [3:0] osc_pin
);
   logic [3:0] pin_r = 4'h0;
   int cnt_r = 0;
   int slow_r = 0;
   // four sources offered
   // the rc pin runs faster than the rest, so a wrong pick shifts the wake time and divider gaps
   always @(posedge sys_clk) begin
      cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
      slow_r <= (slow_r == HALF) ? 0 : slow_r + 1;
      if (cnt_r == HALF - 1) begin
         pin_r[1] <= ~pin_r[1];
      end
      if (slow_r == HALF) begin
         pin_r[0] <= ~pin_r[0];
         pin_r[3:2] <= ~pin_r[3:2];
      end
   end
   assign osc_pin = pin_r;
endmodule : ccr_osc_model

// [bench/ccr_top_tb.sv]
`timescale 1ns/100ps
`include "ccr_regs.svh"
module ccr_top_tb;
   import ccr_pkg::*;
   localparam int WD = 20;
   localparam int OP = 4;
   localparam int XP = 6;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] osc_pin;
   ccr_src_t cfg_src = CCR_SRC_RC;
   logic rtc_on_xtal = 1'b0;
   logic [3:0] rst_req = 4'h0;
   logic wake_req = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, cpu_tick, periph_tick, periph_clk, machine_cycle;
   logic clkout, clkout_oe, low_power, irq;
   logic [5:0] trim;
   logic [7:0] wdt_ctrl;
   logic [31:0] rd;
   int miscompares = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #5 sys_clk = ~sys_clk;

   ccr_osc_model osc (.sys_clk, .osc_pin);
   ccr_top #(.WAKE_DLY_CYC(WD)) dut (.sys_clk, .arst_n, .osc_pin, .cfg_src, .rtc_on_xtal,
      .rst_req, .wake_req, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_tick, .periph_tick,
      .periph_clk, .machine_cycle, .clkout, .clkout_oe, .trim, .low_power, .wdt_ctrl, .irq);

   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic results();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // the request stands until the edge that sees waitrequest low; that edge takes the data
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask : rdchk

   task automatic settle();
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : settle

   task automatic wake(input int lo);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (cpu_tick !== 1'b1);
      chk(n >= lo && n <= lo + 16, 1'b1);
   endtask : wake

   task automatic por(input ccr_src_t s, input int lo);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      cfg_src <= s;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      wake(lo);
   endtask : por

   task automatic gap(output int g);
      g = 0;
      do @(negedge sys_clk); while (cpu_tick !== 1'b1);
      do begin
         @(negedge sys_clk);
         g++;
      end while (cpu_tick !== 1'b1);
   endtask : gap

   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_vals(input logic [31:0] stat);
      rdchk(`CCR_OFS_DIV, 32'h0000_0000);
      rdchk(`CCR_OFS_TRIM, 32'h0000_0020);
      chk(trim, 6'h20);
      rdchk(`CCR_OFS_AUX, 32'h0000_0000);
      rdchk(`CCR_OFS_CAUSE, 32'h0000_0030);
      rdchk(`CCR_OFS_WDC, 32'h0000_00E5);
      chk(wdt_ctrl, 8'hE5);
      rdchk(`CCR_OFS_STAT, stat);
   endtask : t_vals

   task automatic t_irq();
      rdchk(`CCR_OFS_IST, 32'h0000_0001);
      chk(irq, 1'b0);
      bus(1'b1, `CCR_OFS_IMSK, 32'h0000_0001);
      settle();
      chk(irq, 1'b1);
      bus(1'b1, `CCR_OFS_IST, 32'h0000_0001);
      settle();
      chk(irq, 1'b0);
      rdchk(`CCR_OFS_IST, 32'h0000_0000);
   endtask : t_irq

   // a restart replays the whole wake-up delay; the extra edge lets a tick already in flight pass
   task automatic t_wake();
      @(posedge sys_clk);
      wake_req <= 1'b1;
      @(posedge sys_clk);
      wake_req <= 1'b0;
      @(posedge sys_clk);
      wake(223 * OP + WD);
      chk(irq, 1'b1);
   endtask : t_wake

   // a crystal source keeps the pin undriven even with the enable set
   task automatic t_xtal_pin();
      bus(1'b1, `CCR_OFS_TRIM, 32'h0000_0040);
      settle();
      chk(clkout_oe, 1'b0);
   endtask : t_xtal_pin

   task automatic t_bits();
      bus(1'b1, `CCR_OFS_TRIM, 32'h0000_00FF);
      rdchk(`CCR_OFS_TRIM, 32'h0000_007F);
      chk(trim, 6'h3F);
      bus(1'b1, `CCR_OFS_WDC, 32'h0000_00FF);
      rdchk(`CCR_OFS_WDC, 32'h0000_00E7);
      bus(1'b1, `CCR_OFS_WDC, 32'h0000_00E5);
      bus(1'b1, `CCR_OFS_AUX, 32'h0000_00FF);
      rdchk(`CCR_OFS_AUX, 32'h0000_0080);
      chk(low_power, 1'b1);
      avs_byteenable <= 4'h0;
      bus(1'b1, `CCR_OFS_TRIM, 32'h0000_0000);
      avs_byteenable <= 4'hF;
      rdchk(`CCR_OFS_TRIM, 32'h0000_007F);
      bus(1'b1, 5'h1F, 32'h0000_00FF);
      rdchk(5'h1F, 32'h0000_0000);
   endtask : t_bits

   task automatic t_clkout();
      settle();
      chk(clkout_oe, 1'b1);
      chk(clkout, periph_clk);
      @(posedge sys_clk);
      rtc_on_xtal <= 1'b1;
      settle();
      chk(clkout_oe, 1'b0);
      @(posedge sys_clk);
      rtc_on_xtal <= 1'b0;
      bus(1'b1, `CCR_OFS_TRIM, 32'h0000_003F);
      settle();
      chk(clkout_oe, 1'b0);
   endtask : t_clkout

   // a watchdog cause must keep trim and set the timeout flag, a software cause keeps it
   task automatic t_soft(input logic [3:0] src, input logic [31:0] cause);
      @(posedge sys_clk);
      rst_req <= src;
      @(posedge sys_clk);
      rst_req <= 4'h0;
      settle();
      chk(trim, 6'h3F);
      chk(low_power, 1'b0);
      chk(wdt_ctrl, 8'hE7);
      rdchk(`CCR_OFS_CAUSE, cause);
   endtask : t_soft

   // window opens just after a cpu tick, so eight ticks hold four peripheral ticks
   task automatic t_div(input logic [7:0] n);
      int g, pt, mc, t, tg;
      logic lst;
      bus(1'b1, `CCR_OFS_DIV, {24'h00_0000, n});
      gap(g);
      gap(g);
      chk(g, (n == 8'h00) ? OP : 2 * n * OP);
      pt = 0;
      mc = 0;
      t = 0;
      tg = 0;
      lst = clkout;
      while (t < 8) begin
         @(negedge sys_clk);
         t += cpu_tick;
         pt += periph_tick;
         mc += machine_cycle;
         tg += (clkout != lst);
         lst = clkout;
      end
      chk(pt, 4);
      chk(mc, 4);
      chk(tg, 8);
   endtask : t_div

   // ------------------------------
   // run control
   // ------------------------------
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         results();
      end
   end

   initial begin
      por(CCR_SRC_RC, 223 * OP + WD);
      t_vals(32'h0000_0003);
      t_irq();
      t_wake();
      t_bits();
      t_clkout();
      t_soft(4'h2, 32'h0000_0032);
      bus(1'b1, `CCR_OFS_AUX, 32'h0000_0080);
      t_soft(4'h4, 32'h0000_0036);
      t_div(8'h00);
      t_div(8'h01);
      rdchk(`CCR_OFS_IST, 32'h0000_0003);
      t_div(8'hFF);
      por(CCR_SRC_XTAL, 991 * XP + WD);
      t_vals(32'h0000_0001);
      t_xtal_pin();
      results();
   end
endmodule : ccr_top_tb
